/* asrc_defines.svh */
// Offsets, field positions, reset values and fixed counts of the rate converter.
// Assumes inclusion by bare name from the converter module.
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH
`define ASRC_REG_CLK_CTRL 8'h00
`define ASRC_REG_DLY_MUTE 8'h01
`define ASRC_REG_ERROR 8'h02
`define ASRC_REG_OUT_PER 8'h03
`define ASRC_CLK_CTRL_RST 8'h00
`define ASRC_DLY_MUTE_RST 8'h00
`define ASRC_ERROR_RST 8'h00
`define ASRC_CLK_SRC_LSB 0
`define ASRC_CLK_DIV_BIT 2
`define ASRC_DLY_MSB 6
`define ASRC_MUTE_BIT 7
`define ASRC_ERR_SETTLE_BIT 0
`define ASRC_ERR_IRQ_EN_BIT 1
`define ASRC_MIN_OFFSET 9'h010
`define ASRC_RAM_DEPTH 512
`define ASRC_ONE_STEP 27'h0100000
`define ASRC_ROLL_BIT 26
`define ASRC_BASE_TAPS 10'h040
`define ASRC_RATIO_UNITY 11'h100
`define ASRC_RATIO_HYST 11'h002
`define ASRC_SETTLE_THRESH 29'h0000400
`define ASRC_SETTLE_COUNT 4'hf
`define ASRC_GAIN_FULL 8'hff
`define ASRC_KI_FAST 4
`define ASRC_KI_SLOW 10
`define ASRC_KP_FAST 2
`define ASRC_KP_SLOW 6
`define ASRC_OUT_SHIFT 15
`endif

/* asrc_pkg.sv */
// Types shared by the rate converter.
// Assumes nothing beyond the constant header.
`default_nettype none
package asrc_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MAC_L = 2'b01,
		ST_MAC_R = 2'b10,
		ST_DONE = 2'b11
	} asrc_state_t;
	typedef logic signed [23:0] asrc_sample_t;
endpackage
`default_nettype wire

/* asrc_core.sv */
// Stereo asynchronous rate converter: input FIFO, servo loop, polyphase MAC.
// Assumes i_sys_clk is the converter master clock and all strobes are synchronous to it.
// Function
// - One convolution per channel per output period, 64 taps unless decimating.
// - Input faster: cutoff lowered, taps grow by ratio.
// - Input faster: stored samples scaled by output/input.
// - FIFO holds 512 words per channel.
// - Write offset is 16 plus delay bits 6:0.
// - Delay bit 7 ramps audio softly to mute.
// - Input counter gives write address and servo ramp.
// - Servo integer is RAM start, fraction ROM start.
// - Input faster: servo fraction divided by rate ratio.
// - Servo fast after start or rate change, then slow.
// - Settling indicator set while servo is fast.
// - Optional interrupt on fast to slow change.
// - Convolution loads start pointers, RAM address decrements.
// - ROM step one unit or scaled; rollover ends.
// - Both channels share one multiply-accumulate unit.
// - Ratio changes only beyond a hysteresis of two input counts.
// - Coefficients interpolated between few stored entries.
// - Output period averaged from coarse measurements.
// - Control register picks clock source and divider.
`include "asrc_defines.svh"
`default_nettype none
module asrc_core
	import asrc_pkg::*;
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Register port.
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Master clock selection towards the clock tree.
	output logic [1:0] o_mclk_src,
	output logic o_mclk_div,
	// Input samples from the audio source.
	input wire logic i_in_valid,
	input wire logic [23:0] i_in_left,
	input wire logic [23:0] i_in_right,
	// Output sample strobe and samples to the audio sink.
	input wire logic i_out_tick,
	output logic o_out_valid,
	output logic [23:0] o_out_left,
	output logic [23:0] o_out_right,
	// Settling event.
	output logic o_settle_irq
);
	logic [7:0] clk_ctrl_q, dly_q, gain_q, win_q;
	logic irq_en_q, fast_q, fast_d, ratio_upd, dec, conv_dec_q;
	logic [8:0] wr_cnt_q;
	asrc_sample_t ram_l [`ASRC_RAM_DEPTH];
	asrc_sample_t ram_r [`ASRC_RAM_DEPTH];
	logic [10:0] ratio_q, in_cnt_q;
	logic [15:0] per_meas_q, per_avg_q;
	logic [28:0] pos_q, step_q, err, i_term;
	logic [3:0] calm_q;
	asrc_state_t state_q;
	logic [8:0] ram_addr_q;
	logic [26:0] rom_ptr_q, rom_inc_q, rom_next;
	logic signed [47:0] acc_l_q, acc_r_q;
	logic [9:0] tap_q;
	logic [16:0] scale;
	// Stored coefficient entries: a raised-cosine window, 17 points over the span.
	function automatic logic [11:0] tbl(input logic [4:0] k);
		case (k)
			5'd1, 5'd15: tbl = 12'h027;
			5'd2, 5'd14: tbl = 12'h096;
			5'd3, 5'd13: tbl = 12'h13f;
			5'd4, 5'd12: tbl = 12'h200;
			5'd5, 5'd11: tbl = 12'h2c1;
			5'd6, 5'd10: tbl = 12'h36a;
			5'd7, 5'd9: tbl = 12'h3d9;
			5'd8: tbl = 12'h400;
			default: tbl = 12'h000;
		endcase
	endfunction
	// Coefficient from the ROM pointer by interpolating two stored entries.
	function automatic logic signed [17:0] coef(input logic [26:0] p);
		logic signed [13:0] a, b;
		logic signed [23:0] d;
		a = $signed({2'b00, tbl({1'b0, p[25:22]})});
		b = $signed({2'b00, tbl({1'b0, p[25:22]} + 5'd1)});
		d = (b - a) * $signed({1'b0, p[21:14]});
		coef = 18'(a) + 18'(d >>> 8);
	endfunction
	// Product of a sample with an unsigned 8.8 gain.
	function automatic logic [23:0] scl(input logic [23:0] s, input logic [16:0] g);
		logic signed [41:0] m;
		m = $signed(s) * $signed({1'b0, g});
		scl = m[31:8];
	endfunction
	assign o_mclk_src = clk_ctrl_q[`ASRC_CLK_SRC_LSB +: 2];
	assign o_mclk_div = clk_ctrl_q[`ASRC_CLK_DIV_BIT];
	assign dec = ratio_q > `ASRC_RATIO_UNITY;
	assign scale = 17'h10000 / {6'h00, (ratio_q == 11'h000) ? 11'h001 : ratio_q};
	// Register writes.
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn)
		begin
			clk_ctrl_q <= `ASRC_CLK_CTRL_RST;
			dly_q <= `ASRC_DLY_MUTE_RST;
			irq_en_q <= 1'b0;
		end
		else if (i_reg_wr)
		begin
			if (i_reg_addr == `ASRC_REG_CLK_CTRL)
				clk_ctrl_q <= i_reg_wdata;
			if (i_reg_addr == `ASRC_REG_DLY_MUTE)
				dly_q <= i_reg_wdata;
			if (i_reg_addr == `ASRC_REG_ERROR)
				irq_en_q <= i_reg_wdata[`ASRC_ERR_IRQ_EN_BIT];
		end
	// Register reads, answered one cycle after the strobe.
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn)
			o_reg_rdata <= 8'h00;
		else if (i_reg_rd)
			case (i_reg_addr)
				`ASRC_REG_CLK_CTRL: o_reg_rdata <= clk_ctrl_q;
				`ASRC_REG_DLY_MUTE: o_reg_rdata <= dly_q;
				`ASRC_REG_ERROR: o_reg_rdata <= {6'h00, irq_en_q, fast_q};
				`ASRC_REG_OUT_PER: o_reg_rdata <= per_avg_q[11:4];
				default: o_reg_rdata <= 8'h00;
			endcase
	// Input counter, soft-mute ramp and FIFO writes at offset.
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn)
		begin
			wr_cnt_q <= 9'h000;
			gain_q <= 8'h00;
		end
		else if (i_in_valid)
		begin
			wr_cnt_q <= wr_cnt_q + 9'h001;
			if (dly_q[`ASRC_MUTE_BIT] && gain_q != 8'h00)
				gain_q <= gain_q - 8'h01;
			else if (!dly_q[`ASRC_MUTE_BIT] && gain_q != `ASRC_GAIN_FULL)
				gain_q <= gain_q + 8'h01;
		end
	// Sample storage; mute gain and, when decimating, the rate scale are applied first.
	always_ff @(posedge i_sys_clk)
		if (i_in_valid)
		begin
			ram_l[wr_cnt_q + `ASRC_MIN_OFFSET + {2'b00, dly_q[`ASRC_DLY_MSB:0]}] <=
				scl(scl(i_in_left, {9'h000, gain_q}), dec ? scale : 17'h00100);
			ram_r[wr_cnt_q + `ASRC_MIN_OFFSET + {2'b00, dly_q[`ASRC_DLY_MSB:0]}] <=
				scl(scl(i_in_right, {9'h000, gain_q}), dec ? scale : 17'h00100);
		end
	// Rate ratio: inputs counted over 256 output periods, with hysteresis.
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn)
		begin
			ratio_q <= `ASRC_RATIO_UNITY;
			in_cnt_q <= 11'h000;
			win_q <= 8'h00;
			ratio_upd <= 1'b0;
		end
		else
		begin
			ratio_upd <= 1'b0;
			if (i_out_tick)
				win_q <= win_q + 8'h01;
			if (i_out_tick && win_q == 8'hff)
			begin
				in_cnt_q <= {10'h000, i_in_valid};
				if ((in_cnt_q > ratio_q + `ASRC_RATIO_HYST) ||
					(ratio_q > in_cnt_q + `ASRC_RATIO_HYST))
				begin
					ratio_q <= in_cnt_q;
					ratio_upd <= 1'b1;
				end
			end
			else if (i_in_valid && in_cnt_q != 11'h7ff)
				in_cnt_q <= in_cnt_q + 11'h001;
		end
	// Coarse output period measurements averaged over time.
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn)
		begin
			per_meas_q <= 16'h0000;
			per_avg_q <= 16'h0000;
		end
		else if (i_out_tick)
		begin
			per_meas_q <= 16'h0000;
			per_avg_q <= per_avg_q + 16'($signed({1'b0, per_meas_q} - {1'b0, per_avg_q}) >>> 3);
		end
		else if (per_meas_q != 16'hffff)
			per_meas_q <= per_meas_q + 16'h0001;
	// Servo ramp filter tracking the input counter, gains set by mode.
	assign err = {wr_cnt_q, 20'h00000} - pos_q;
	assign i_term = fast_q ? 29'($signed(err) >>> `ASRC_KI_FAST) : 29'($signed(err) >>> `ASRC_KI_SLOW);
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn)
		begin
			pos_q <= 29'h0000000;
			step_q <= 29'h0100000;
		end
		else if (i_out_tick)
		begin
			step_q <= step_q + i_term;
			pos_q <= pos_q + step_q + i_term + (fast_q ? 29'($signed(err) >>> `ASRC_KP_FAST) :
				29'($signed(err) >>> `ASRC_KP_SLOW));
		end
	// Mode: fast after reset or ratio change; slow once ramp change stays small.
	always_comb
	begin
		fast_d = fast_q;
		if (ratio_upd)
			fast_d = 1'b1;
		else if (i_out_tick && calm_q == `ASRC_SETTLE_COUNT)
			fast_d = 1'b0;
	end
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn)
		begin
			fast_q <= 1'b1;
			calm_q <= 4'h0;
			o_settle_irq <= 1'b0;
		end
		else
		begin
			fast_q <= fast_d;
			o_settle_irq <= fast_q && !fast_d && irq_en_q;
			if (ratio_upd)
				calm_q <= 4'h0;
			else if (i_out_tick)
			begin
				if ((i_term[28] ? -i_term : i_term) < `ASRC_SETTLE_THRESH)
					calm_q <= (calm_q == `ASRC_SETTLE_COUNT) ? calm_q : calm_q + 4'h1;
				else
					calm_q <= 4'h0;
			end
		end
	// Convolution sequencer with a single MAC alternating left and right.
	assign rom_next = rom_ptr_q + rom_inc_q;
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn)
		begin
			state_q <= ST_IDLE;
			ram_addr_q <= 9'h000;
			rom_ptr_q <= 27'h0000000;
			rom_inc_q <= `ASRC_ONE_STEP;
			acc_l_q <= 48'sh0;
			acc_r_q <= 48'sh0;
			tap_q <= 10'h000;
			conv_dec_q <= 1'b0;
		end
		else
			case (state_q)
				ST_IDLE:
					if (i_out_tick)
					begin
						ram_addr_q <= pos_q[28:20];
						rom_ptr_q <= dec ? {7'h00, 20'(({16'h0000, pos_q[19:0]} * {19'h0, scale}) >> 8)}
							: {7'h00, pos_q[19:0]};
						rom_inc_q <= dec ? {scale[14:0], 12'h000} : `ASRC_ONE_STEP;
						conv_dec_q <= dec;
						acc_l_q <= 48'sh0;
						acc_r_q <= 48'sh0;
						tap_q <= 10'h000;
						state_q <= ST_MAC_L;
					end
				ST_MAC_L:
				begin
					acc_l_q <= acc_l_q + 48'(ram_l[ram_addr_q] * coef(rom_ptr_q));
					state_q <= ST_MAC_R;
				end
				ST_MAC_R:
				begin
					acc_r_q <= acc_r_q + 48'(ram_r[ram_addr_q] * coef(rom_ptr_q));
					ram_addr_q <= ram_addr_q - 9'h001;
					rom_ptr_q <= rom_next;
					tap_q <= tap_q + 10'h001;
					state_q <= rom_next[`ASRC_ROLL_BIT] ? ST_DONE : ST_MAC_L;
				end
				default:
					state_q <= ST_IDLE;
			endcase
	// Output samples registered once per convolution.
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn)
		begin
			o_out_valid <= 1'b0;
			o_out_left <= 24'h000000;
			o_out_right <= 24'h000000;
		end
		else
		begin
			o_out_valid <= state_q == ST_DONE;
			if (state_q == ST_DONE)
			begin
				o_out_left <= 24'(acc_l_q >>> `ASRC_OUT_SHIFT);
				o_out_right <= 24'(acc_r_q >>> `ASRC_OUT_SHIFT);
			end
		end
	a_full_taps: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(state_q == ST_DONE && !conv_dec_q) |-> tap_q == `ASRC_BASE_TAPS)
		else $error("Undecimated convolution did not run its full tap count.");
	a_long_conv: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(state_q == ST_IDLE && i_out_tick && dec) |=> rom_inc_q < `ASRC_ONE_STEP)
		else $error("Decimating convolution did not shrink the ROM step.");
	a_mute_ramp: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_in_valid && dly_q[`ASRC_MUTE_BIT] && gain_q != 8'h00) |=> gain_q == $past(gain_q) - 8'h01)
		else $error("Mute ramp did not step down by one.");
	a_wr_count: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_in_valid |=> wr_cnt_q == $past(wr_cnt_q) + 9'h001)
		else $error("Input counter did not advance on an input sample.");
	a_start_load: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(state_q == ST_IDLE && i_out_tick) |=> ram_addr_q == $past(pos_q[28:20]) ##1 state_q == ST_MAC_R)
		else $error("Convolution did not load the servo RAM pointer.");
	a_fast_entry: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		ratio_upd |=> fast_q [*2])
		else $error("Servo not in fast mode after a ratio change.");
	a_settle_read: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_reg_rd && i_reg_addr == `ASRC_REG_ERROR) |=> o_reg_rdata[0] == $past(fast_q))
		else $error("Settling indicator does not show the servo mode.");
	a_settle_irq: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_settle_irq |-> !fast_q && $past(fast_q) && $past(irq_en_q))
		else $error("Settling event without a fast to slow change.");
	a_ram_step: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(state_q == ST_MAC_R) |=> ram_addr_q == $past(ram_addr_q) - 9'h001)
		else $error("RAM address did not decrement by one per tap.");
	a_rom_end: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(state_q == ST_MAC_R && rom_next[`ASRC_ROLL_BIT]) |=> state_q == ST_DONE ##1 o_out_valid)
		else $error("ROM rollover did not end the convolution.");
	a_ratio_hyst: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		$changed(ratio_q) |-> ($past(in_cnt_q) > $past(ratio_q) + `ASRC_RATIO_HYST
			|| $past(ratio_q) > $past(in_cnt_q) + `ASRC_RATIO_HYST))
		else $error("Ratio changed within the hysteresis band.");
endmodule // asrc_core
`default_nettype wire

/* asrc_partner.sv */
// Audio source and sink stand-in that feeds the rate converter bench.
// Assumes one master clock shared with the converter and an active-low reset.
`default_nettype none
module asrc_partner
#(
	parameter int PERIOD = 256,
	parameter logic [23:0] LEVEL = 24'h100000
)
(
	// Clock, reset and run control.
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_run,
	// Streams towards the converter.
	output logic o_in_valid,
	output logic [23:0] o_in_left,
	output logic [23:0] o_in_right,
	output logic o_out_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] phase_q;
	logic strobe;
	assign strobe = i_run && phase_q == 9'h064;
	// One output period spans 256 master clocks.
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			phase_q <= 9'h000;
		else if (i_run)
			phase_q <= (phase_q == 9'(PERIOD - 1)) ? 9'h000 : phase_q + 9'h001;
	end
	// One stereo sample per period; data lines show the inverse outside the strobe.
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_in_valid <= 1'b0;
			o_out_tick <= 1'b0;
			o_in_left <= 24'h000000;
			o_in_right <= 24'h000000;
		end
		else
		begin
			o_in_valid <= strobe;
			o_out_tick <= i_run && phase_q == 9'h000;
			o_in_left <= strobe ? LEVEL : ~LEVEL;
			o_in_right <= strobe ? -LEVEL : ~(-LEVEL);
		end
	end
endmodule // asrc_partner
`default_nettype wire

/* asrc_core_bench.sv */
// Self-checking bench of the rate converter: registers, output timing, settling, fade-in.
// Assumes the partner model supplies both streams on the master clock.
`default_nettype none
module asrc_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic run = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [8:0] lat = 9'h000;
	logic signed [23:0] first_l;
	wire logic [7:0] rdata;
	wire logic [1:0] clk_sel;
	wire logic clk_div, in_valid, out_tick, out_valid, settle_irq;
	wire logic [23:0] in_l, in_r, out_l, out_r;
	int mismatches = 0;
	int checked = 0;
	int ticks = 0, valids = 0, irqs = 0, cycles = 0;
	// Converter and its audio neighbours.
	asrc_core i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
		.o_mclk_src(clk_sel), .o_mclk_div(clk_div), .i_in_valid(in_valid),
		.i_in_left(in_l), .i_in_right(in_r), .i_out_tick(out_tick),
		.o_out_valid(out_valid), .o_out_left(out_l), .o_out_right(out_r),
		.o_settle_irq(settle_irq));
	asrc_partner i_audio (.i_sys_clk(clk), .i_rstn(rstn), .i_run(run), .o_in_valid(in_valid),
		.o_in_left(in_l), .o_in_right(in_r), .o_out_tick(out_tick));
	// Master clock of 50 MHz.
	initial
		forever #10 clk = ~clk;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// Passes only when lo < got < hi; an unknown falls through to the failure.
	task automatic near(input logic signed [23:0] got, input logic signed [23:0] lo,
		input logic signed [23:0] hi, input string what);
		checked++;
		if (got > lo && got < hi)
			return;
		mismatches++;
		$display("CHECK FAILED at %0t: %s got %h", $time, what, got);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data is registered at the strobe edge and looked at just after it.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check({16'h0000, rdata}, {16'h0000, exp}, what);
	endtask
	// Watches output timing and settling events, and cuts a hang short.
	always @(posedge clk)
	begin
		lat <= (out_tick === 1'b1) ? 9'h001 : lat + 9'h001;
		cycles++;
		if (out_tick === 1'b1)
			ticks++;
		if (settle_irq === 1'b1)
			irqs++;
		if (out_valid === 1'b1)
		begin
			valids++;
			check({15'h0000, lat}, 24'h000082, "latency");
		end
		if (cycles == 70000)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: run too long", $time);
			report_and_stop();
		end
	end
	// Main sequence of tests.
	initial
	begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(8'h00, 8'h00, "clock control reset");
		rd(8'h01, 8'h00, "delay reset");
		rd(8'h02, 8'h01, "error reset");
		wr(8'h10, 8'h5a);
		rd(8'h10, 8'h00, "unmapped");
		$display("test reset_values done");
		wr(8'h00, 8'h07);
		wr(8'h01, 8'h85);
		rd(8'h00, 8'h07, "clock control");
		check({22'h000000, clk_sel}, 24'h000003, "source");
		check({23'h000000, clk_div}, 24'h000001, "divider");
		rd(8'h01, 8'h85, "delay and mute");
		wr(8'h00, 8'h00);
		wr(8'h01, 8'h00);
		wr(8'h02, 8'hff);
		rd(8'h02, 8'h03, "error write");
		$display("test registers done");
		run <= 1'b1;
		repeat (120 * 256) @(posedge clk);
		first_l = out_l;
		repeat (100 * 256) @(posedge clk);
		near(first_l, 24'sh000000, out_l, "fade in");
		near(out_l, 24'sh080000, 24'sh100000, "left level");
		near(out_r, 24'shf00000, 24'shf80000, "right level");
		check({23'h000000, valids == ticks || valids + 1 == ticks}, 24'h000001, "outputs");
		check(24'(irqs), 24'h000001, "settle events");
		wr(8'h01, 8'h80);
		repeat (4 * 256) @(posedge clk);
		rd(8'h01, 8'h80, "mute during stream");
		wr(8'h01, 8'h00);
		rd(8'h03, 8'h0f, "output period");
		rd(8'h02, 8'h02, "settled");
		$display("test stream done");
		report_and_stop();
	end
endmodule // asrc_core_bench
`default_nettype wire
